// [shared/uip_map.svh]
`ifndef UIP_MAP_SVH
`define UIP_MAP_SVH
//------------------------------------------------------------------------------
// Functional notes
// - Line error flags raise level one.
// - Line status read clears; flags persist.
// - Time-out reports level two, code 0x0c.
// - Time-out after idle; receive read clears.
// - Data ready reports level three, code 0x04.
// - Trigger pending until count below level.
// - Transmit empty level four; identity read or transmit hold write clears.
// - Modem change level five; modem read clears.
// - Xoff/special level six; several clears.
// - Flow pin rise level seven; clears on reads.
// - Idle reads 0x01, or 0xC1 with the queue enabled; lowest level wins.
// - Control write-only, identity read-only, shared offset.
// - Mode 0 receive request while data held.
// - Mode 0 transmit request while queue empty.
// - Mode 1 receive request trigger/timeout, until empty.
// - Mode 1 transmit request empty/free, until full.
// - Bits 7:6 pick receive trigger level.
// - Shallow variant levels 14, 8, 4, 1.
// - Deep variant levels 60, 56, 16, 8.
// - Identity read holds indication, records events.
//------------------------------------------------------------------------------

// Register byte offsets: printed offsets are not word multiples, so index*4.
`define UIP_IDX_IDENTITY   4'h2
`define UIP_ADDR_IDENTITY  8'h08
`define UIP_ADDR_ENABLE    8'h04
`define UIP_ADDR_LINE      8'h14
`define UIP_ADDR_MODEM     8'h18
`define UIP_ADDR_RXBUF     8'h00
`define UIP_ADDR_TXHOLD    8'h00
`define UIP_ADDR_STATUS    8'h20
`define UIP_ADDR_CONFIG    8'h24

// Reset values.
`define UIP_CTRL_RST       8'h00
`define UIP_ENA_RST        8'h00
`define UIP_IDENT_IDLE     8'h01

// Field positions.
`define UIP_CTRL_FIFO_EN   0
`define UIP_CTRL_DMA_SEL   3
`define UIP_CTRL_TRIG_HI   7
`define UIP_CTRL_TRIG_LO   6
`define UIP_ENA_RXDATA     0
`define UIP_ENA_TXEMPTY    1
`define UIP_ENA_LINE       2
`define UIP_ENA_MODEM      3
`define UIP_ENA_XOFF       5
`define UIP_ENA_RTS        6
`define UIP_ENA_CTS        7

// Identity codes for bits 5:0.
`define UIP_ID_LINE        6'h06
`define UIP_ID_TIMEOUT     6'h0c
`define UIP_ID_RXDATA      6'h04
`define UIP_ID_TXEMPTY     6'h02
`define UIP_ID_MODEM       6'h00
`define UIP_ID_XOFF        6'h10
`define UIP_ID_FLOW        6'h20
`define UIP_ID_NONE        6'h01

// Trigger levels, shallow and deep variants.
`define UIP_TRIG16_0       7'd1
`define UIP_TRIG16_1       7'd4
`define UIP_TRIG16_2       7'd8
`define UIP_TRIG16_3       7'd14
`define UIP_TRIG64_0       7'd8
`define UIP_TRIG64_1       7'd16
`define UIP_TRIG64_2       7'd56
`define UIP_TRIG64_3       7'd60
`define UIP_DEPTH16        7'd16
`define UIP_DEPTH64        7'd64
`endif

// [shared/uip_pkg.sv]
package uip_pkg;
   // AXI4-Lite write request channels.
   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
   } uip_axw_req_t;
   typedef struct packed {
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } uip_axr_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } uip_ax_rsp_t;
   // Status from the surrounding channel logic.
   typedef struct packed {
      logic [3:0] line_err;
      logic [3:0] modem_delta;
      logic       rx_timeout;
      logic       xoff_seen;
      logic       special_seen;
      logic       xon_seen;
      logic       char_seen;
      logic       cts_in;
      logic       rts_out;
      logic       auto_cts;
      logic       auto_rts;
      logic [6:0] rx_count;
      logic [6:0] tx_count;
      logic [6:0] tx_thresh;
   } uip_chan_t;
   typedef enum logic [1:0] {UIP_OK = 2'h0, UIP_SLVERR = 2'h2} uip_resp_t;
   typedef enum logic [3:0] {
      UIP_RD_IDLE = 4'b0001,
      UIP_RD_HOLD = 4'b0010,
      UIP_RD_RESP = 4'b0100,
      UIP_RD_DONE = 4'b1000
   } uip_rd_state_t;
endpackage

// [hw/uip_core.sv]
`timescale 1ns/10ps
`include "uip_map.svh"
module uip_core (
   // Clock and reset.
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // Register bus.
   input  wire uip_pkg::uip_axw_req_t axw,
   input  wire uip_pkg::uip_axr_req_t axr,
   output uip_pkg::uip_ax_rsp_t      axs,
   // Channel status and strobes.
   input  wire uip_pkg::uip_chan_t   chan,
   input  wire logic                 deep_variant,
   output logic                      rx_buf_read,
   output logic                      tx_hold_write,
   output logic [7:0]                tx_hold_data,
   output logic                      line_read,
   // DMA request pins.
   output logic                      rx_dma_request_n,
   output logic                      tx_dma_request_n
);
   import uip_pkg::*;

   //---------------------------------------------------------------------------
   // Registers and state.
   //---------------------------------------------------------------------------
   logic [7:0]    queue_control_ff;
   logic [7:0]    interrupt_enable_reg_ff;
   logic [7:0]    interrupt_identity_ff;
   logic [7:0]    nxt_identity;
   logic          line_pend_ff, timeout_pend_ff, tx_pend_ff, modem_pend_ff;
   logic          xoff_pend_ff, flow_pend_ff;
   logic [3:0]    line_err_prev_ff;
   logic          cts_prev_ff, rts_prev_ff;
   logic          rx_req_ff, tx_req_ff;
   logic          tx_empty_prev_ff;
   uip_rd_state_t rd_st_ff;
   logic [7:0]    rd_addr_ff;
   logic [31:0]   rdata_ff;
   logic          aw_have_ff, w_have_ff, bvalid_ff;
   logic [7:0]    aw_addr_ff;
   logic [31:0]   wdata_ff;
   logic [3:0]    wstrb_ff;

   // Trigger level decode, used for interrupt and DMA logic alike.
   function automatic logic [6:0] trig_level(input logic [1:0] code,
                                             input logic deep);
      unique case ({deep, code})
         3'b000:  trig_level = `UIP_TRIG16_0;
         3'b001:  trig_level = `UIP_TRIG16_1;
         3'b010:  trig_level = `UIP_TRIG16_2;
         3'b011:  trig_level = `UIP_TRIG16_3;
         3'b100:  trig_level = `UIP_TRIG64_0;
         3'b101:  trig_level = `UIP_TRIG64_1;
         3'b110:  trig_level = `UIP_TRIG64_2;
         default: trig_level = `UIP_TRIG64_3;
      endcase
   endfunction

   // Word-address match helper for the bus decode.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a[7:2] == r[7:2]);
   endfunction

   //---------------------------------------------------------------------------
   // Write channel: address and data taken in either order.
   //---------------------------------------------------------------------------
   logic wr_go;
   logic wr_ctrl, wr_ena, wr_tx, wr_cfg, wr_known;
   assign wr_go    = aw_have_ff && w_have_ff && !bvalid_ff;
   assign wr_ctrl  = wr_go && hit(aw_addr_ff, `UIP_ADDR_IDENTITY);
   assign wr_ena   = wr_go && hit(aw_addr_ff, `UIP_ADDR_ENABLE);
   assign wr_tx    = wr_go && hit(aw_addr_ff, `UIP_ADDR_TXHOLD);
   assign wr_cfg   = wr_go && hit(aw_addr_ff, `UIP_ADDR_CONFIG);
   assign wr_known = wr_ctrl || wr_ena || wr_tx || wr_cfg;

   // Address and data latches; a new item is refused until the response is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         aw_addr_ff <= 8'h00;
         wdata_ff   <= 32'h0000_0000;
         wstrb_ff   <= 4'h0;
         bvalid_ff  <= 1'b0;
      end else begin
         if (axw.awvalid && !aw_have_ff) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= axw.awaddr;
         end
         if (axw.wvalid && !w_have_ff) begin
            w_have_ff <= 1'b1;
            wdata_ff  <= axw.wdata;
            wstrb_ff  <= axw.wstrb;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
         end
         if (bvalid_ff && axw.bready) begin
            bvalid_ff  <= 1'b0;
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
         end
      end
   end

   // Response code latch.
   logic [1:0] bresp_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_ff <= UIP_OK;
      end else if (wr_go) begin
         bresp_ff <= wr_known ? UIP_OK : UIP_SLVERR;
      end
   end

   // Control and enable registers; only byte lane 0 carries data.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         queue_control_ff        <= `UIP_CTRL_RST;
         interrupt_enable_reg_ff <= `UIP_ENA_RST;
      end else begin
         if (wr_ctrl && wstrb_ff[0]) begin
            queue_control_ff <= wdata_ff[7:0];
         end
         if (wr_ena && wstrb_ff[0]) begin
            interrupt_enable_reg_ff <= wdata_ff[7:0];
         end
      end
   end

   assign tx_hold_write = wr_tx && wstrb_ff[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_hold_data <= 8'h00;
      end else if (tx_hold_write) begin
         tx_hold_data <= wdata_ff[7:0];
      end
   end

   //---------------------------------------------------------------------------
   // Read channel: one-hot machine, the identity is captured at the request.
   //---------------------------------------------------------------------------
   logic rd_take, rd_ident, rd_line, rd_modem, rd_rx;
   assign rd_take  = (rd_st_ff == UIP_RD_IDLE) && axr.arvalid;
   assign rd_ident = rd_take && hit(axr.araddr, `UIP_ADDR_IDENTITY);
   assign rd_line  = rd_take && hit(axr.araddr, `UIP_ADDR_LINE);
   assign rd_modem = rd_take && hit(axr.araddr, `UIP_ADDR_MODEM);
   assign rd_rx    = rd_take && hit(axr.araddr, `UIP_ADDR_RXBUF);
   assign rx_buf_read = rd_rx;
   assign line_read   = rd_line;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_ff   <= UIP_RD_IDLE;
         rd_addr_ff <= 8'h00;
      end else begin
         unique case (rd_st_ff)
            UIP_RD_IDLE: begin
               if (axr.arvalid) begin
                  rd_st_ff   <= UIP_RD_HOLD;
                  rd_addr_ff <= axr.araddr;
               end
            end
            UIP_RD_HOLD: rd_st_ff <= UIP_RD_RESP;
            UIP_RD_RESP: begin
               if (axr.rready) begin
                  rd_st_ff <= UIP_RD_DONE;
               end
            end
            UIP_RD_DONE: rd_st_ff <= UIP_RD_IDLE;
         endcase
      end
   end

   // Identity is frozen from the request until the cycle after the answer.
   logic ident_busy;
   assign ident_busy = (rd_st_ff != UIP_RD_IDLE) && hit(rd_addr_ff, `UIP_ADDR_IDENTITY);

   // Read data, captured while the request is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (rd_take) begin
         if (hit(axr.araddr, `UIP_ADDR_IDENTITY)) begin
            rdata_ff <= {24'h00_0000, interrupt_identity_ff};
         end else if (hit(axr.araddr, `UIP_ADDR_ENABLE)) begin
            rdata_ff <= {24'h00_0000, interrupt_enable_reg_ff};
         end else if (hit(axr.araddr, `UIP_ADDR_LINE)) begin
            rdata_ff <= {27'h000_0000, chan.line_err, 1'b0};
         end else if (hit(axr.araddr, `UIP_ADDR_MODEM)) begin
            rdata_ff <= {28'h000_0000, chan.modem_delta};
         end else if (hit(axr.araddr, `UIP_ADDR_STATUS)) begin
            rdata_ff <= {24'h00_0000, rx_req_ff, tx_req_ff, flow_pend_ff,
                         xoff_pend_ff, modem_pend_ff, tx_pend_ff,
                         timeout_pend_ff, line_pend_ff};
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end
   end

   logic [1:0] rresp_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rresp_ff <= UIP_OK;
      end else if (rd_take) begin
         rresp_ff <= (rd_ident || rd_line || rd_modem || rd_rx ||
                      hit(axr.araddr, `UIP_ADDR_ENABLE) ||
                      hit(axr.araddr, `UIP_ADDR_STATUS)) ? UIP_OK : UIP_SLVERR;
      end
   end

   //---------------------------------------------------------------------------
   // Pending sources; a new event wins over a clear in the same cycle.
   //---------------------------------------------------------------------------
   logic [6:0] trig;
   logic       fifo_on, rx_trig_hit, tx_empty, line_new, cts_rise, rts_rise;
   assign trig        = trig_level(queue_control_ff[`UIP_CTRL_TRIG_HI:`UIP_CTRL_TRIG_LO],
                                   deep_variant);
   assign fifo_on     = queue_control_ff[`UIP_CTRL_FIFO_EN];
   assign rx_trig_hit = fifo_on ? (chan.rx_count >= trig) : (chan.rx_count != 7'd0);
   assign tx_empty    = (chan.tx_count == 7'd0);
   assign line_new    = |(chan.line_err & ~line_err_prev_ff);
   assign cts_rise    = chan.auto_cts && chan.cts_in && !cts_prev_ff;
   assign rts_rise    = chan.auto_rts && chan.rts_out && !rts_prev_ff;

   // Edge history for the event sources.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_err_prev_ff <= 4'h0;
         cts_prev_ff      <= 1'b0;
         rts_prev_ff      <= 1'b0;
         tx_empty_prev_ff <= 1'b0;
      end else begin
         line_err_prev_ff <= chan.line_err;
         cts_prev_ff      <= chan.cts_in;
         rts_prev_ff      <= chan.rts_out;
         tx_empty_prev_ff <= tx_empty;
      end
   end

   // Line status pending clears on a status read; the error flags themselves
   // live with the characters outside and stay until those are drained.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_pend_ff <= 1'b0;
      end else if (line_new) begin
         line_pend_ff <= 1'b1;
      end else if (rd_line || chan.line_err == 4'h0) begin
         line_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_pend_ff <= 1'b0;
      end else if (chan.rx_timeout) begin
         timeout_pend_ff <= 1'b1;
      end else if (rd_rx) begin
         timeout_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pend_ff <= 1'b0;
      end else if (tx_empty && !tx_empty_prev_ff) begin
         tx_pend_ff <= 1'b1;
      end else if (tx_hold_write || (rd_ident && interrupt_identity_ff[5:0] == `UIP_ID_TXEMPTY)) begin
         tx_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modem_pend_ff <= 1'b0;
      end else if (chan.modem_delta != 4'h0) begin
         modem_pend_ff <= 1'b1;
      end else if (rd_modem) begin
         modem_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xoff_pend_ff <= 1'b0;
      end else if (chan.xoff_seen || chan.special_seen) begin
         xoff_pend_ff <= 1'b1;
      end else if (rd_ident || chan.xon_seen || chan.char_seen) begin
         xoff_pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flow_pend_ff <= 1'b0;
      end else if (cts_rise || rts_rise) begin
         flow_pend_ff <= 1'b1;
      end else if (rd_ident || rd_modem) begin
         flow_pend_ff <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Priority encode, lowest level first.
   //---------------------------------------------------------------------------
   logic [7:0] ena;
   assign ena = interrupt_enable_reg_ff;
   always_comb begin
      nxt_identity[7:6] = {2{fifo_on}};
      if (line_pend_ff && ena[`UIP_ENA_LINE]) begin
         nxt_identity[5:0] = `UIP_ID_LINE;
      end else if (timeout_pend_ff && ena[`UIP_ENA_RXDATA]) begin
         nxt_identity[5:0] = `UIP_ID_TIMEOUT;
      end else if (rx_trig_hit && ena[`UIP_ENA_RXDATA]) begin
         nxt_identity[5:0] = `UIP_ID_RXDATA;
      end else if (tx_pend_ff && ena[`UIP_ENA_TXEMPTY]) begin
         nxt_identity[5:0] = `UIP_ID_TXEMPTY;
      end else if (modem_pend_ff && ena[`UIP_ENA_MODEM]) begin
         nxt_identity[5:0] = `UIP_ID_MODEM;
      end else if (xoff_pend_ff && ena[`UIP_ENA_XOFF]) begin
         nxt_identity[5:0] = `UIP_ID_XOFF;
      end else if (flow_pend_ff && (ena[`UIP_ENA_CTS] || ena[`UIP_ENA_RTS])) begin
         nxt_identity[5:0] = `UIP_ID_FLOW;
      end else begin
         nxt_identity[5:0] = `UIP_ID_NONE;
      end
   end

   // The indication is refreshed each clock except while an identity read is open.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interrupt_identity_ff <= `UIP_IDENT_IDLE;
      end else if (!ident_busy && !rd_ident) begin
         interrupt_identity_ff <= nxt_identity;
      end
   end

   //---------------------------------------------------------------------------
   // DMA request pins, active low, registered.
   //---------------------------------------------------------------------------
   logic mode1;
   logic [6:0] depth, tx_free;
   assign mode1   = fifo_on && queue_control_ff[`UIP_CTRL_DMA_SEL];
   assign depth   = deep_variant ? `UIP_DEPTH64 : `UIP_DEPTH16;
   assign tx_free = 7'(depth - chan.tx_count);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_req_ff <= 1'b0;
      end else if (!mode1) begin
         rx_req_ff <= (chan.rx_count != 7'd0);
      end else if (chan.rx_count == trig || chan.rx_timeout) begin
         rx_req_ff <= 1'b1;
      end else if (chan.rx_count == 7'd0) begin
         rx_req_ff <= 1'b0;
      end
   end

   // In mode 1 the deep part also requests on free space above threshold, the shallow only on empty.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_req_ff <= 1'b0;
      end else if (!mode1) begin
         tx_req_ff <= tx_empty;
      end else if (tx_empty || (deep_variant && tx_free > chan.tx_thresh)) begin
         tx_req_ff <= 1'b1;
      end else if (chan.tx_count == depth) begin
         tx_req_ff <= 1'b0;
      end
   end

   assign rx_dma_request_n = !rx_req_ff;
   assign tx_dma_request_n = !tx_req_ff;

   //---------------------------------------------------------------------------
   // Bus answers.
   //---------------------------------------------------------------------------
   always_comb begin
      axs.awready = !aw_have_ff;
      axs.wready  = !w_have_ff;
      axs.bvalid  = bvalid_ff;
      axs.bresp   = bresp_ff;
      axs.arready = (rd_st_ff == UIP_RD_IDLE);
      axs.rvalid  = (rd_st_ff == UIP_RD_RESP);
      axs.rdata   = rdata_ff;
      axs.rresp   = rresp_ff;
   end
endmodule // uip_core

// [testbench/uip_core_chk.sv]
`timescale 1ns/10ps
module uip_core_chk (
   // Clock and reset.
   input wire logic                  aclk,
   input wire logic                  aresetn,
   // Register bus.
   input wire uip_pkg::uip_axw_req_t axw,
   input wire uip_pkg::uip_axr_req_t axr,
   input wire uip_pkg::uip_ax_rsp_t  axs,
   // Channel side and request pins.
   input wire uip_pkg::uip_chan_t    chan,
   input wire logic                  deep_variant,
   input wire logic                  rx_buf_read,
   input wire logic                  tx_hold_write,
   input wire logic [7:0]            tx_hold_data,
   input wire logic                  line_read,
   input wire logic                  rx_dma_request_n,
   input wire logic                  tx_dma_request_n
);
   import uip_pkg::*;
   // ---------------
   // Port properties
   // ---------------
   // Three cycles of history, so the edge that leaves reset is never judged.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_RX_EMPTY: assert property ((chan.rx_count == 7'h00) [*3] |-> rx_dma_request_n)
      else $error("rx request low on empty queue");
   AST_TX_FULL: assert property ((chan.tx_count == (deep_variant ? 7'h40 : 7'h10)) [*3]
      |-> tx_dma_request_n) else $error("tx request low on full queue");
   AST_TX_EMPTY: assert property ((chan.tx_count == 7'h00 && !deep_variant) [*3]
      |-> !tx_dma_request_n) else $error("tx request high on empty queue");
   AST_LINE_RD: assert property (line_read |-> axr.arvalid && axs.arready
      && axr.araddr == 8'h14) else $error("line strobe without line read");
   AST_RXBUF_RD: assert property (rx_buf_read |-> axr.arvalid && axs.arready
      && axr.araddr == 8'h00) else $error("buffer strobe without buffer read");
   AST_RXBUF_ONE: assert property (rx_buf_read |=> !rx_buf_read)
      else $error("buffer strobe longer than one cycle");
   AST_TXW_DONE: assert property (tx_hold_write |=> axs.bvalid && axs.bresp == 2'h0)
      else $error("transmit strobe without good response");
   AST_RD_ANSWER: assert property (axr.arvalid && axs.arready |-> ##[2:3] axs.rvalid)
      else $error("read answer late");
   AST_WR_ANSWER: assert property (axw.awvalid && axs.awready && axw.wvalid && axs.wready
      |-> ##[1:2] axs.bvalid) else $error("write answer late");
endmodule // uip_core_chk

bind uip_core uip_core_chk uip_core_chk_i (.aclk(aclk), .aresetn(aresetn), .axw(axw),
   .axr(axr), .axs(axs), .chan(chan), .deep_variant(deep_variant),
   .rx_buf_read(rx_buf_read), .tx_hold_write(tx_hold_write), .tx_hold_data(tx_hold_data),
   .line_read(line_read), .rx_dma_request_n(rx_dma_request_n),
   .tx_dma_request_n(tx_dma_request_n));

// [testbench/uip_chan_model.sv]
`timescale 1ns/10ps
module uip_chan_model (
   // Clock.
   input wire logic         aclk,
   // Strobes from the block.
   input wire logic         rx_buf_read,
   input wire logic         tx_hold_write,
   // Channel status.
   output uip_pkg::uip_chan_t chan
);
   import uip_pkg::*;
   // -------------
   // Channel state
   // -------------
   uip_chan_t st = '0;
   assign chan = st;
   // Reads take a character and writes add one; events last one cycle, since a held
   // event would look like a fresh one every clock.
   always @(posedge aclk) begin
      if (rx_buf_read && st.rx_count != 7'h00) begin
         st.rx_count <= st.rx_count - 7'h01;
      end
      if (tx_hold_write) begin
         st.tx_count <= st.tx_count + 7'h01;
      end
      if (st.rx_timeout || st.xoff_seen || st.xon_seen || st.modem_delta != 4'h0) begin
         st.rx_timeout <= 1'b0;
         st.xon_seen <= 1'b0;
         st.xoff_seen <= 1'b0;
         st.modem_delta <= 4'h0;
      end
   end
endmodule // uip_chan_model

// [testbench/tb_uart_irq_priority_dma_ready.sv]
`timescale 1ns/10ps
module tb_uart_irq_priority_dma_ready;
   import uip_pkg::*;
   // -------
   // Harness
   // -------
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic         deep_variant = 1'b0;
   uip_axw_req_t axw = '0;
   uip_axr_req_t axr = '0;
   uip_ax_rsp_t  axs;
   uip_chan_t    chan;
   logic         rx_buf_read;
   logic         tx_hold_write;
   logic [7:0]   tx_hold_data;
   logic         line_read;
   logic         rx_dma_request_n;
   logic         tx_dma_request_n;
   logic [31:0]  d;
   logic [1:0]   r;
   logic [6:0]   lvl [8] = '{7'd1, 7'd4, 7'd8, 7'd14, 7'd8, 7'd16, 7'd56, 7'd60};
   int           failures = 0;
   int           check_count = 0;
   int           cycles = 0;
   always #2 aclk = ~aclk;
   uip_core uip_core_i (.aclk(aclk), .aresetn(aresetn), .axw(axw), .axr(axr), .axs(axs),
      .chan(chan), .deep_variant(deep_variant), .rx_buf_read(rx_buf_read),
      .tx_hold_write(tx_hold_write), .tx_hold_data(tx_hold_data), .line_read(line_read),
      .rx_dma_request_n(rx_dma_request_n), .tx_dma_request_n(tx_dma_request_n));
   uip_chan_model uip_chan_model_i (.aclk(aclk), .rx_buf_read(rx_buf_read),
      .tx_hold_write(tx_hold_write), .chan(chan));
   // A hung handshake would stall forever, so the run is capped.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus master: each channel held until its own ready, responses until seen.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge aclk);
      axw.awaddr <= a;
      axw.awvalid <= 1'b1;
      axw.wdata <= {24'h0, v};
      axw.wstrb <= 4'h1;
      axw.wvalid <= 1'b1;
      axw.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (axs.awready) axw.awvalid <= 1'b0;
         if (axs.wready) axw.wvalid <= 1'b0;
      end while (!axs.bvalid);
      axw.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      axr.araddr <= a;
      axr.arvalid <= 1'b1;
      axr.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (axs.arready) axr.arvalid <= 1'b0;
      end while (!axs.rvalid);
      d = axs.rdata;
      r = axs.rresp;
      axr.rready <= 1'b0;
   endtask
   task automatic idc(input logic [5:0] e);
      @(posedge aclk); // The indication trails its pending flags by one clock.
      rd(8'h08);
      chk("identity", {26'h0, e}, {26'h0, d[5:0]});
   endtask
   task automatic setq(input logic [6:0] rc, input logic [6:0] tc);
      @(posedge aclk);
      uip_chan_model_i.st.rx_count <= rc;
      uip_chan_model_i.st.tx_count <= tc;
      repeat (3) @(posedge aclk);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_mode0();
      idc(6'h01);
      rd(8'h3c);
      chk("unmapped resp", 32'h2, {30'h0, r});
      wr(8'h08, 8'h00);
      setq(7'd1, 7'd0);
      chk("rx pin", 32'h0, {31'h0, rx_dma_request_n});
      chk("tx pin", 32'h0, {31'h0, tx_dma_request_n});
      setq(7'd0, 7'd16);
      chk("rx pin", 32'h1, {31'h0, rx_dma_request_n});
      chk("tx pin", 32'h1, {31'h0, tx_dma_request_n});
   endtask
   task automatic t_trig();
      wr(8'h04, 8'h01);
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         deep_variant <= i[2];
         wr(8'h08, {i[1:0], 6'h09});
         setq(lvl[i] - 7'd1, 7'd1);
         idc(6'h01);
         chk("rx pin", 32'h1, {31'h0, rx_dma_request_n});
         setq(lvl[i], 7'd1);
         idc(6'h04);
         chk("rx pin", 32'h0, {31'h0, rx_dma_request_n});
         chk("tx pin", {31'h0, ~i[2]}, {31'h0, tx_dma_request_n});
         setq(lvl[i] - 7'd1, 7'd1);
         idc(6'h01);
         chk("rx pin", {31'h0, lvl[i] == 7'd1}, {31'h0, rx_dma_request_n});
         setq(7'd0, 7'd1);
         chk("rx pin", 32'h1, {31'h0, rx_dma_request_n});
      end
   endtask
   task automatic t_prio();
      @(posedge aclk);
      deep_variant <= 1'b0;
      wr(8'h08, 8'h01);
      wr(8'h04, 8'h0d);
      @(posedge aclk);
      uip_chan_model_i.st.line_err <= 4'h2;
      uip_chan_model_i.st.modem_delta <= 4'h1;
      setq(7'd1, 7'd1);
      idc(6'h06);
      chk("identity fifo", 32'h3, {30'h0, d[7:6]});
      @(posedge aclk);
      uip_chan_model_i.st.line_err <= 4'h0;
      rd(8'h14);
      idc(6'h04);
      @(posedge aclk);
      uip_chan_model_i.st.rx_timeout <= 1'b1;
      idc(6'h0c);
      rd(8'h00);
      idc(6'h00);
      rd(8'h18);
      idc(6'h01);
      setq(7'd0, 7'd0);
      wr(8'h04, 8'hef);
      idc(6'h02);
      idc(6'h01);
      setq(7'd0, 7'd1);
      setq(7'd0, 7'd0);
      wr(8'h00, 8'h5a);
      idc(6'h01);
      chk("tx data", 32'h5a, {24'h0, tx_hold_data});
      @(posedge aclk);
      uip_chan_model_i.st.xoff_seen <= 1'b1;
      idc(6'h10);
      idc(6'h01);
      uip_chan_model_i.st.xoff_seen <= 1'b1;
      setq(7'd0, 7'd1);
      uip_chan_model_i.st.xon_seen <= 1'b1;
      idc(6'h01);
      @(posedge aclk);
      uip_chan_model_i.st.auto_cts <= 1'b1;
      @(posedge aclk);
      uip_chan_model_i.st.cts_in <= 1'b1;
      idc(6'h20);
      idc(6'h01);
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_mode0();
      t_trig();
      t_prio();
      complete_run();
   end
endmodule // tb_uart_irq_priority_dma_ready
